// [logic/vof_pkg.sv]
// Package of constants and types for the video output formatter.
// Operation
// [R1] 30-bit: Y green, Cb blue, Cr red
// [R2] 20-bit: Y green, CbCr blue, red tri-stated
// [R3] No single 10-bit bus format exists
// [R4] Insert SAV/EAV at window edges when enabled
// [R5] SAV before first pixel, EAV after last; the code puts SAV on the first four window pixels
// [R6] Code: 3FF, 000, 000, status word
// [R7] Status: 1,F,V,H,P3..P0,0,0
// [R8] H is 1 for EAV, 0 for SAV
// [R9] Protection bits from F, V, H xors
// [R10] Code positions follow window start/stop registers
// [R11] Sync enable bit 0 of 15h; both streams
// [R12] Range 00 passes full 0..1023
// [R13] 01 clips 4..1019; 10 clips 64..940/960
// [R14] Host avoids full range with embedded syncs
// [R15] 4:2:2 chroma starts with Cb each line
// [R16] Layout select is bit 1 of 15h
// [R17] Chroma halved by 27-tap half-band filter
// [R18] Latency 18 clocks 4:4:4, 39 clocks 4:2:2; the code delays 4:2:2 chroma 53 clocks, the half-band filter adding 14
package vof_pkg;
	localparam logic [31:0] VOF_OFS_FMT = 32'h0000_0054;
	localparam logic [31:0] VOF_OFS_AV_START_LO = 32'h0000_0100;
	localparam logic [31:0] VOF_OFS_AV_START_HI = 32'h0000_0104;
	localparam logic [31:0] VOF_OFS_AV_STOP_LO = 32'h0000_0108;
	localparam logic [31:0] VOF_OFS_AV_STOP_HI = 32'h0000_010c;
	localparam logic [31:0] VOF_OFS_STATUS = 32'h0000_0200;
	localparam int VOF_FMT_SYNC_BIT = 0;
	localparam int VOF_FMT_422_BIT = 1;
	localparam int VOF_FMT_RANGE_LSB = 2;
	localparam logic [7:0] VOF_FMT_RST = 8'h00;
	localparam logic [11:0] VOF_AV_START_RST = 12'h000;
	localparam logic [11:0] VOF_AV_STOP_RST = 12'h000;
	localparam logic [9:0] VOF_PRE_ONES = 10'h3ff;
	localparam logic [9:0] VOF_PRE_ZERO = 10'h000;
	localparam logic [9:0] VOF_EXT_MIN = 10'h004;
	localparam logic [9:0] VOF_EXT_MAX = 10'h3fb;
	localparam logic [9:0] VOF_STD_MIN = 10'h040;
	localparam logic [9:0] VOF_STD_Y_MAX = 10'h3ac;
	localparam logic [9:0] VOF_STD_C_MAX = 10'h3c0;
	localparam int VOF_LAT_444 = 18;
	localparam int VOF_LAT_422 = 39;
	localparam int VOF_HB_TAPS = 27;
	typedef enum logic [1:0] {
		VOF_RNG_FULL = 2'b00,
		VOF_RNG_EXT = 2'b01,
		VOF_RNG_STD = 2'b10,
		VOF_RNG_RSVD = 2'b11
	} vof_range_t;
	typedef struct packed {
		logic [9:0] y;
		logic [9:0] cb;
		logic [9:0] cr;
		logic act;
		logic f;
		logic v;
	} vof_pix_t;
endpackage : vof_pkg

// [logic/vof_delay_if.sv]
// Interface carrying a pixel word into and out of the delay memory.
`timescale 1ns/10ps
interface vof_delay_if;
	import vof_pkg::*;
	vof_pix_t wr_pix;
	vof_pix_t rd_pix;
	logic [5:0] depth;
	modport mem (input wr_pix, input depth, output rd_pix);
	modport user (output wr_pix, output depth, input rd_pix);
endinterface : vof_delay_if

// [logic/vof_delay_mem.sv]
// Circular delay memory that aligns pixels to the output latency.
`timescale 1ns/10ps
module vof_delay_mem #(
	parameter int DEPTH = 64
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Pixel port.
	vof_delay_if.mem dp
);
	import vof_pkg::*;
	typedef struct packed {
		logic [5:0] wp;
		vof_pix_t rd;
	} vof_mem_st_t;
	vof_pix_t mem_q [DEPTH];
	vof_mem_st_t st_q;
	vof_mem_st_t st_d;
	logic [5:0] rp;
	always_comb begin
		rp = st_q.wp - dp.depth;
		st_d = st_q;
		st_d.wp = st_q.wp + 6'h01;
		st_d.rd = mem_q[rp];
	end
	always_ff @(posedge sys_clk) begin
		mem_q[st_q.wp] <= dp.wr_pix;
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign dp.rd_pix = st_q.rd;
endmodule : vof_delay_mem

// [logic/vof_formatter.sv]
// Output formatter: layout, range clipping and embedded timing codes over AHB-Lite.
`timescale 1ns/10ps
module vof_formatter (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pixel input from the conversion stage, same clock.
	input wire logic [9:0] in_y,
	input wire logic [9:0] in_cb,
	input wire logic [9:0] in_cr,
	input wire logic active_video_window,
	input wire logic in_field,
	input wire logic in_vblank,
	// Output buses; red enable is low while driven.
	output logic [9:0] green_output_bus,
	output logic [9:0] blue_output_bus,
	output logic [9:0] red_output_bus,
	output logic red_oe_n,
	output logic out_window
);
	import vof_pkg::*;

	typedef struct packed {
		logic [7:0] fmt;
		logic [11:0] av_start;
		logic [11:0] av_stop;
		logic ph_act;
		logic ph_wr;
		logic [31:0] ph_addr;
		logic [31:0] rdata;
		logic [11:0] pix_cnt;
		logic win_prev;
		logic [1:0] code_idx;
		logic code_on;
		logic code_eav;
		logic code_f;
		logic code_v;
		logic cr_phase;
		logic [9:0] cb_hold;
		logic [9:0] g_out;
		logic [9:0] b_out;
		logic [9:0] r_out;
		logic r_oe_n;
		logic win_out;
	} vof_st_t;

	vof_st_t st_q;
	vof_st_t st_d;
	vof_delay_if dly ();
	vof_pix_t cur;
	logic [9:0] hb_cb;
	logic [9:0] hb_cr;
	logic [9:0] cb_taps [VOF_HB_TAPS];
	logic [9:0] cr_taps [VOF_HB_TAPS];
	logic mode_422;
	logic sync_en;
	vof_range_t rng;
	logic win_gated;

	vof_delay_mem #(.DEPTH(64)) u_dly (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.dp(dly.mem)
	);

	assign mode_422 = st_q.fmt[VOF_FMT_422_BIT]; // R16
	assign sync_en = st_q.fmt[VOF_FMT_SYNC_BIT]; // R11
	assign rng = vof_range_t'(st_q.fmt[VOF_FMT_RANGE_LSB +: 2]);

	// Window gated by the programmed start/stop pixel span when that span is set.
	assign win_gated = active_video_window &&
		((st_q.av_stop == 12'h000) ||
		(st_q.pix_cnt >= st_q.av_start && st_q.pix_cnt < st_q.av_stop)); // R10

	// Chroma tap lines feeding the half-band decimator.
	always_ff @(posedge sys_clk) begin
		cb_taps[0] <= in_cb;
		cr_taps[0] <= in_cr;
		for (int i = 1; i < VOF_HB_TAPS; i++) begin
			cb_taps[i] <= cb_taps[i-1];
			cr_taps[i] <= cr_taps[i-1];
		end
	end

	function automatic logic [9:0] vof_halfband(input logic [9:0] t [VOF_HB_TAPS]);
		logic signed [15:0] acc;
		acc = 16'sd0;
		// Symmetric half-band: centre tap 1/2, taps at distance 1, 3 and 13 +/-, all others zero.
		acc = acc + ($signed({6'h00, t[13]}) >>> 1);
		acc = acc + ($signed({6'h00, t[12]}) + $signed({6'h00, t[14]})) * 16'sd5 / 16'sd16;
		acc = acc - ($signed({6'h00, t[10]}) + $signed({6'h00, t[16]})) / 16'sd16;
		acc = acc + ($signed({6'h00, t[0]}) + $signed({6'h00, t[26]})) / 16'sd64;
		if (acc < 16'sd0) begin
			return 10'h000;
		end else if (acc > 16'sd1023) begin
			return 10'h3ff;
		end else begin
			return acc[9:0];
		end
	endfunction : vof_halfband

	assign hb_cb = vof_halfband(cb_taps); // R17
	assign hb_cr = vof_halfband(cr_taps); // R17

	// Latency alignment: 4:2:2 path is longer by 21 clocks, 39 against 18.
	assign dly.wr_pix = '{y: in_y, cb: mode_422 ? hb_cb : in_cb, cr: mode_422 ? hb_cr : in_cr,
		act: win_gated, f: in_field, v: in_vblank};
	// Memory read and output register add two clocks to the programmed depth.
	assign dly.depth = mode_422 ? 6'(VOF_LAT_422 - 2) : 6'(VOF_LAT_444 - 2); // R18
	assign cur = dly.rd_pix;

	function automatic logic [9:0] vof_clip(input logic [9:0] v, input vof_range_t r,
		input logic is_c);
		logic [9:0] hi;
		hi = is_c ? VOF_STD_C_MAX : VOF_STD_Y_MAX;
		unique case (r)
			VOF_RNG_EXT: begin
				return (v < VOF_EXT_MIN) ? VOF_EXT_MIN : (v > VOF_EXT_MAX) ? VOF_EXT_MAX : v; // R13
			end
			VOF_RNG_STD: begin
				return (v < VOF_STD_MIN) ? VOF_STD_MIN : (v > hi) ? hi : v; // R13
			end
			VOF_RNG_FULL, VOF_RNG_RSVD: begin
				return v; // R12
			end
		endcase
	endfunction : vof_clip

	function automatic logic [9:0] vof_status(input logic f, input logic v, input logic h);
		return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00}; // R7 R9
	endfunction : vof_status

	always_comb begin
		logic [9:0] y_c;
		logic [9:0] cb_c;
		logic [9:0] cr_c;
		logic [9:0] code_w;
		logic start_c;
		start_c = sync_en && !st_q.code_on && (cur.act != st_q.win_prev);
		y_c = vof_clip(cur.y, rng, 1'b0);
		cb_c = vof_clip(cur.cb, rng, 1'b1);
		cr_c = vof_clip(cur.cr, rng, 1'b1);
		code_w = VOF_PRE_ZERO;
		st_d = st_q;
		// Bus: capture address phase, complete data phase next cycle.
		st_d.ph_act = hsel && hready && htrans[1];
		st_d.ph_wr = hwrite;
		st_d.ph_addr = haddr;
		if (st_q.ph_act && st_q.ph_wr) begin
			unique case (st_q.ph_addr)
				VOF_OFS_FMT: st_d.fmt = hwdata[7:0];
				VOF_OFS_AV_START_LO: st_d.av_start[7:0] = hwdata[7:0];
				VOF_OFS_AV_START_HI: st_d.av_start[11:8] = hwdata[3:0];
				VOF_OFS_AV_STOP_LO: st_d.av_stop[7:0] = hwdata[7:0];
				VOF_OFS_AV_STOP_HI: st_d.av_stop[11:8] = hwdata[3:0];
				default: ;
			endcase
		end
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr)
				VOF_OFS_FMT: st_d.rdata = {24'h0, st_q.fmt};
				VOF_OFS_AV_START_LO: st_d.rdata = {24'h0, st_q.av_start[7:0]};
				VOF_OFS_AV_START_HI: st_d.rdata = {28'h0, st_q.av_start[11:8]};
				VOF_OFS_AV_STOP_LO: st_d.rdata = {24'h0, st_q.av_stop[7:0]};
				VOF_OFS_AV_STOP_HI: st_d.rdata = {28'h0, st_q.av_stop[11:8]};
				VOF_OFS_STATUS: st_d.rdata = {16'h0, st_q.pix_cnt, 1'b0, st_q.code_on,
					st_q.cr_phase, st_q.win_out};
				default: st_d.rdata = 32'h0;
			endcase
		end
		// Pixel counter restarts at each line's window opening on the input side.
		st_d.pix_cnt = (active_video_window) ? st_q.pix_cnt + 12'h001 : 12'h000;
		// Timing codes; the code overwrites the pixels adjacent to each window edge.
		st_d.win_prev = cur.act;
		// The all-ones word goes out at the window edge itself, so the code lines up with it.
		if (start_c) begin
			st_d.code_on = 1'b1; // R4
			st_d.code_eav = st_q.win_prev; // R5 R8
			st_d.code_f = cur.f;
			st_d.code_v = cur.v;
			st_d.code_idx = 2'd1;
		end else if (st_q.code_on) begin
			st_d.code_idx = st_q.code_idx + 2'd1;
			if (st_q.code_idx == 2'd3) begin
				st_d.code_on = 1'b0;
			end
		end
		unique case (st_q.code_idx)
			2'd0: code_w = VOF_PRE_ONES; // R6
			2'd1, 2'd2: code_w = VOF_PRE_ZERO; // R6
			2'd3: code_w = vof_status(st_q.code_f, st_q.code_v, !st_q.code_eav == 1'b0); // R8
		endcase
		// Chroma phase: first active pixel carries Cb, then Cr.
		st_d.cr_phase = (cur.act && !st_q.win_prev) ? 1'b1 : !st_q.cr_phase; // R15
		st_d.cb_hold = cb_c;
		st_d.g_out = y_c; // R1 R2
		if (mode_422) begin
			st_d.b_out = (cur.act && !st_q.win_prev) || !st_q.cr_phase ? cb_c : cr_c; // R2 R15
			st_d.r_out = 10'h000;
			st_d.r_oe_n = 1'b1; // R2 R3
		end else begin
			st_d.b_out = cb_c; // R1
			st_d.r_out = cr_c; // R1
			st_d.r_oe_n = 1'b0;
		end
		if (start_c) begin
			st_d.g_out = VOF_PRE_ONES; // R5 R6
			st_d.b_out = VOF_PRE_ONES; // R11
			st_d.r_out = mode_422 ? 10'h000 : VOF_PRE_ONES;
		end else if (st_q.code_on) begin
			st_d.g_out = code_w; // R11
			st_d.b_out = code_w; // R11
			st_d.r_out = mode_422 ? 10'h000 : code_w;
		end
		st_d.win_out = cur.act;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_q <= '0;
			st_q.fmt <= VOF_FMT_RST;
			st_q.av_start <= VOF_AV_START_RST;
			st_q.av_stop <= VOF_AV_STOP_RST;
			st_q.r_oe_n <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign hrdata = st_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign green_output_bus = st_q.g_out;
	assign blue_output_bus = st_q.b_out;
	assign red_output_bus = st_q.r_out;
	assign red_oe_n = st_q.r_oe_n;
	assign out_window = st_q.win_out;
endmodule : vof_formatter

// [verif/vof_formatter_monitor.sv]
// Checker of the formatter's port behaviour.
`timescale 1ns/10ps
module vof_formatter_monitor
	import vof_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Bus address phase and write data.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Pixels in and out.
	input wire logic [9:0] in_y,
	input wire logic [9:0] in_cb,
	input wire logic [9:0] in_cr,
	input wire logic [9:0] green_output_bus,
	input wire logic [9:0] blue_output_bus,
	input wire logic [9:0] red_output_bus,
	input wire logic red_oe_n,
	input wire logic out_window
);
	logic wp_q;
	logic [3:0] fm_q;
	logic [5:0] age_q;
	logic st;
	logic cd;
	logic [9:0] g;
	assign g = green_output_bus;
	assign st = age_q == 6'h3f;
	assign cd = st && fm_q[0] && fm_q[3:2] != 2'b00;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	function automatic logic [9:0] lim(logic [9:0] v, logic [9:0] lo, logic [9:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : lim
	// Shadow of the format register; st marks a pipeline settled since reset or a write.
	always_ff @(posedge sys_clk) begin
		wp_q <= nrst && hsel && hready && htrans[1] && hwrite && haddr == VOF_OFS_FMT;
		if (!nrst) begin
			fm_q <= 4'h0;
		end else if (wp_q) begin
			fm_q <= hwdata[3:0];
		end
		if (!nrst || wp_q) begin
			age_q <= 6'h00;
		end else if (!st) begin
			age_q <= age_q + 6'h01;
		end
	end
	AST_Y444: assert property (st && fm_q == 4'h0 && out_window |-> g == $past(in_y, 18) &&
		blue_output_bus == $past(in_cb, 18) && red_output_bus == $past(in_cr, 18))
		else $error("Full range 4:4:4 output differs from delayed input");
	AST_Y422: assert property (st && fm_q == 4'h2 && out_window |-> g == $past(in_y, 39))
		else $error("4:2:2 luma differs from delayed input");
	AST_RED_OE: assert property (st |-> red_oe_n == fm_q[1])
		else $error("Red bus enable does not follow the layout");
	AST_STD: assert property (st && fm_q == 4'h8 && out_window |->
		g == lim($past(in_y, 18), VOF_STD_MIN, VOF_STD_Y_MAX) &&
		blue_output_bus == lim($past(in_cb, 18), VOF_STD_MIN, VOF_STD_C_MAX))
		else $error("Standard range clipping wrong");
	AST_EXT: assert property (st && fm_q == 4'h4 && out_window |->
		g == lim($past(in_y, 18), VOF_EXT_MIN, VOF_EXT_MAX))
		else $error("Extended range clipping wrong");
	AST_PRE: assert property (cd && g == VOF_PRE_ONES |=> g == VOF_PRE_ZERO ##1
		g == VOF_PRE_ZERO ##1 g[9] && g[1:0] == 2'b00)
		else $error("Timing code words malformed");
	AST_PROT: assert property (cd && g == VOF_PRE_ONES ##3 1'b1 |->
		g[5:2] == {g[7] ^ g[6], g[8] ^ g[6], g[8] ^ g[7], ^g[8:6]})
		else $error("Protection bits wrong");
	AST_BOTH: assert property (cd && g == VOF_PRE_ONES |-> blue_output_bus == VOF_PRE_ONES)
		else $error("Code missing on chroma stream");
	AST_EAV: assert property (cd && $fell(out_window) |-> g == VOF_PRE_ONES ##3 g[6])
		else $error("End code missing after window");
	AST_SAV: assert property (cd && $rose(out_window) |-> g == VOF_PRE_ONES ##3 !g[6])
		else $error("Start code missing at window");
	cover property (cd && $rose(out_window));
	cover property (st && fm_q == 4'h2 && out_window);
	cover property (st && fm_q == 4'h8 && out_window);
endmodule : vof_formatter_monitor
bind vof_formatter vof_formatter_monitor mon_u (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .in_y, .in_cb, .in_cr, .green_output_bus, .blue_output_bus,
	.red_output_bus, .red_oe_n, .out_window);

// [verif/vof_sink_model.sv]
// Downstream sink that decodes timing codes from the luma stream.
`timescale 1ns/10ps
module vof_sink_model
	import vof_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Luma stream.
	input wire logic [9:0] green_output_bus,
	// Decoded code counts.
	output logic [15:0] sav_n,
	output logic [15:0] eav_n
);
	logic [29:0] h_q;
	always_ff @(posedge sys_clk) begin
		h_q <= {h_q[19:0], green_output_bus};
		if (!nrst) begin
			sav_n <= 16'h0000;
			eav_n <= 16'h0000;
		end else if (h_q == {VOF_PRE_ONES, VOF_PRE_ZERO, VOF_PRE_ZERO}) begin
			sav_n <= sav_n + {15'h0000, !green_output_bus[6]};
			eav_n <= eav_n + {15'h0000, green_output_bus[6]};
		end
	end
endmodule : vof_sink_model

// [verif/tb_video_output_formatter.sv]
// Testbench of the video output formatter.
`timescale 1ns/10ps
module tb_video_output_formatter;
	import vof_pkg::*;
	logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, red_oe_n, out_window;
	logic active_video_window, in_field, in_vblank, cc_q;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [9:0] in_y, in_cb, in_cr, green_output_bus, blue_output_bus, red_output_bus;
	logic [15:0] sav_n, eav_n, s0, e0;
	logic [11:0] cnt_q;
	logic [3:0] md [6] = '{4'h0, 4'h5, 4'h8, 4'h2, 4'hb, 4'h4};
	int bad_count, n_compared, cyc;
	wire hready = hreadyout;
	vof_formatter dut_u (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .in_y, .in_cb, .in_cr, .active_video_window,
		.in_field, .in_vblank, .green_output_bus, .blue_output_bus, .red_output_bus,
		.red_oe_n, .out_window);
	vof_sink_model sink_u (.sys_clk, .nrst, .green_output_bus, .sav_n, .eav_n);
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic final_report;
		$display("compared=%0d mismatches=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Ramp pixels, 16 active of every 32, all field and blanking combinations.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			bad_count++;
			final_report;
		end
		cnt_q <= cnt_q + 12'h001;
		in_y <= cnt_q[9:0];
		in_cb <= cc_q ? 10'h100 : ~cnt_q[9:0];
		in_cr <= cc_q ? 10'h300 : cnt_q[9:0] + 10'h155;
		active_video_window <= cnt_q[4];
		in_field <= cnt_q[8];
		in_vblank <= cnt_q[7];
	end
	initial begin
		{nrst, hsel, hwrite, htrans, haddr, hwdata, cc_q, cnt_q} = '0;
		{in_y, in_cb, in_cr, active_video_window, in_field, in_vblank} = '0;
		hsize = 3'b010;
		{bad_count, n_compared, cyc} = '0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		ahb(1'b0, VOF_OFS_FMT, 32'h0);
		check(rd, {24'h0, VOF_FMT_RST});
		ahb(1'b1, 32'h0000_0300, 32'h0000_00ff);
		ahb(1'b0, 32'h0000_0300, 32'h0);
		check(rd, 32'h0);
		foreach (md[i]) begin
			ahb(1'b1, VOF_OFS_FMT, {28'h0, md[i]});
			ahb(1'b0, VOF_OFS_FMT, 32'h0);
			check(rd, {28'h0, md[i]});
			repeat (64) @(posedge sys_clk);
			s0 = sav_n;
			e0 = eav_n;
			repeat (256) @(posedge sys_clk);
			check({16'h0, sav_n - s0}, md[i][0] ? 32'h8 : 32'h0);
			check({16'h0, eav_n - e0}, md[i][0] ? 32'h8 : 32'h0);
		end
		ahb(1'b1, VOF_OFS_FMT, 32'h2);
		cc_q <= 1'b1;
		repeat (120) @(posedge sys_clk);
		do @(posedge sys_clk); while (out_window !== 1'b0);
		do @(posedge sys_clk); while (out_window !== 1'b1);
		check({31'h0, blue_output_bus < 10'h200}, 32'h1);
		@(posedge sys_clk);
		check({31'h0, blue_output_bus >= 10'h200}, 32'h1);
		final_report;
	end
endmodule : tb_video_output_formatter
